// [rtl/fcp_dead_time.sv]
`timescale 1ns/100ps
// Break-before-make for one output: rising edge delayed, falling immediate
module fcp_dead_time (
   input wire logic clk,
   input wire logic reset,
   input wire logic raw,
   input wire logic [7:0] delayTicks,
   output logic gated
);
   logic [7:0] tickCnt_reg;
   logic [2:0] divCnt_reg;
   logic tick;

   assign tick = (divCnt_reg == 3'(fcp_pkg::DT_DIV - 1));

   always_ff @(posedge clk) begin
      if (reset) begin
         divCnt_reg <= 3'h0;
      end else if (!raw || tick) begin
         divCnt_reg <= 3'h0;
      end else begin
         divCnt_reg <= divCnt_reg + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !raw) begin
         tickCnt_reg <= 8'h00;
         gated <= 1'b0;
      end else if (tickCnt_reg >= delayTicks) begin
         gated <= 1'b1;
      end else if (tick) begin
         tickCnt_reg <= tickCnt_reg + 8'h01;
      end
   end
endmodule

// [rtl/fcp_pkg.sv]
package fcp_pkg;
   // Register numbers of the multifunction register space
   localparam logic [5:0] REG_CFG = 6'h24;
   localparam logic [5:0] REG_ON1 = 6'h25;
   localparam logic [5:0] REG_SHIFT1 = 6'h29;
   localparam logic [5:0] REG_TRIGPOS = 6'h2d;
   localparam logic [5:0] REG_PULSEW = 6'h2e;
   localparam logic [5:0] REG_IRQCFG = 6'h33;
   localparam logic [5:0] REG_FLAGS = 6'h34;
   localparam int NUM_CH = 4;
   localparam int TRIG_A_LSB = 0;
   localparam int TRIG_B_LSB = 16;
   localparam int CFG_ALIGN_LSB = 32;
   localparam int CFG_POL_LSB = 40;
   localparam int CFG_DTLOW_LSB = 48;
   localparam int CFG_DTHIGH_LSB = 56;
   localparam int POL_LOW = 0;
   localparam int POL_HIGH = 1;
   localparam int POL_B = 3;
   localparam int POL_CENTER = 4;
   localparam int POL_A = 5;
   localparam int POL_ZERO = 6;
   localparam int EV_ZERO = 12;
   localparam int EV_CENTER = 13;
   localparam int EV_A = 14;
   localparam int EV_B = 15;
   localparam logic [63:0] CFG_RESET = 64'h0;
   localparam logic [11:0] WORD12_RESET = 12'h000;
   localparam logic [23:0] IRQ_RESET = 24'h000000;
   // Dead-time unit is a 100 MHz tick; 250 MHz core rounds 2.5 up to 3 core cycles
   localparam int CLK_MHZ = 250;
   localparam int DT_TICK_MHZ = 100;
   localparam int DT_DIV = (CLK_MHZ * 2 + DT_TICK_MHZ) / (DT_TICK_MHZ * 2);

   typedef enum logic [1:0] {
      FCP_ALIGN_EDGE = 2'h0,
      FCP_ALIGN_CENTER = 2'h1,
      FCP_ALIGN_INVEDGE = 2'h3,
      FCP_ALIGN_RSVD = 2'h2
   } fcp_align_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [63:0] wdata;
   } fcp_req_t;

   typedef struct packed {
      logic zero;
      logic center;
      logic a;
      logic b;
   } fcp_pulse_t;
endpackage

// [rtl/fcp_pwm_top.sv]
`timescale 1ns/100ps
// Function
// - Each channel stores a 12-bit on-time setting its active duration per period
// - Each channel has a 12-bit shift moving both its output edges
// - Pulse A fires when the common counter equals the A position
// - Pulse B fires when the common counter equals the B position
// - One 8-bit length sets width of A, B, zero and center pulses
// - Interrupt enable register has bits 12 to 15 for PWM events
// - Enabled latched events are ORed onto one interrupt output
// - A two-bit alignment mode applies to all channels together
// - Separate 8-bit dead times in 100 MHz ticks for low and high sides
// - Polarity bits invert low, high, A, B, center and zero outputs
// - Reading the event flag register clears all latched flags
module fcp_pwm_top (
   input wire logic clk,
   input wire logic reset,
   input wire fcp_pkg::fcp_req_t busReq,
   output logic [63:0] rdata,
   output logic [3:0] highSide,
   output logic [3:0] lowSide,
   output fcp_pkg::fcp_pulse_t pulseOut,
   output logic common_event_interrupt_out
);
   logic [63:0] cfg_reg;
   logic [11:0] onTime_reg [fcp_pkg::NUM_CH];
   logic [11:0] shift_reg [fcp_pkg::NUM_CH];
   logic [31:0] trigPos_reg;
   logic [7:0] pulseWidth_reg;
   logic [23:0] irqEnable_reg;
   logic [23:0] flags_reg;
   logic [11:0] cnt_reg;
   logic countDown_reg;
   logic [7:0] zeroCnt_reg, centerCnt_reg, aCnt_reg, bCnt_reg;
   logic [3:0] rawOn_reg;

   wire [11:0] maxCount = cfg_reg[11:0];
   wire [1:0] alignBits = cfg_reg[fcp_pkg::CFG_ALIGN_LSB +: 2];
   wire [6:0] pol = cfg_reg[fcp_pkg::CFG_POL_LSB +: 7];
   wire [7:0] dtLow = cfg_reg[fcp_pkg::CFG_DTLOW_LSB +: 8];
   wire [7:0] dtHigh = cfg_reg[fcp_pkg::CFG_DTHIGH_LSB +: 8];
   wire [11:0] posA = trigPos_reg[fcp_pkg::TRIG_A_LSB +: 12];
   wire [11:0] posB = trigPos_reg[fcp_pkg::TRIG_B_LSB +: 12];
   wire [11:0] halfCount = {1'b0, maxCount[11:1]};
   wire centerMode = (alignBits == fcp_pkg::FCP_ALIGN_CENTER);
   wire invEdge = (alignBits == fcp_pkg::FCP_ALIGN_INVEDGE);
   wire atTop = (cnt_reg == maxCount);
   wire atZero = (cnt_reg == 12'h000);
   // Center mode dwells two cycles at each end; fire only on the turn
   wire periodStart = centerMode ? (atZero && countDown_reg) : atZero;
   wire zeroEvent = periodStart;
   wire centerEvent = centerMode ? (atTop && !countDown_reg)
      : (cnt_reg == halfCount);
   wire cfgWrite = busReq.wr && (busReq.addr == fcp_pkg::REG_CFG);
   wire aEvent = (cnt_reg == posA);
   wire bEvent = (cnt_reg == posB);
   wire flagRead = busReq.rd && (busReq.addr == fcp_pkg::REG_FLAGS);
   wire [23:0] pwmEvents = {8'h00, bEvent, aEvent, centerEvent, zeroEvent,
      12'h000};

   function automatic logic hitReg(input logic [5:0] a, input logic [5:0] r);
      hitReg = busReq.wr && (a == r);
   endfunction

   function automatic logic [7:0] pulseNext(input logic [7:0] c,
         input logic ev, input logic [7:0] w);
      pulseNext = ev ? w : ((c != 8'h00) ? c - 8'h01 : 8'h00);
   endfunction

   // Register writes
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_reg <= fcp_pkg::CFG_RESET;
         trigPos_reg <= 32'h0;
         pulseWidth_reg <= 8'h00;
         irqEnable_reg <= fcp_pkg::IRQ_RESET;
      end else begin
         if (hitReg(busReq.addr, fcp_pkg::REG_CFG)) begin
            cfg_reg <= busReq.wdata;
         end
         if (hitReg(busReq.addr, fcp_pkg::REG_TRIGPOS)) begin
            trigPos_reg <= {4'h0, busReq.wdata[27:16], 4'h0,
               busReq.wdata[11:0]};
         end
         if (hitReg(busReq.addr, fcp_pkg::REG_PULSEW)) begin
            pulseWidth_reg <= busReq.wdata[7:0];
         end
         if (hitReg(busReq.addr, fcp_pkg::REG_IRQCFG)) begin
            irqEnable_reg <= busReq.wdata[23:0];
         end
      end
   end

   // Common counter; edge modes wrap, center mode counts up and down
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 12'h000;
         countDown_reg <= 1'b0;
      end else if (centerMode) begin
         if (atTop && !countDown_reg) begin
            countDown_reg <= 1'b1;
         end else if (atZero && countDown_reg) begin
            countDown_reg <= 1'b0;
         end else if (countDown_reg) begin
            cnt_reg <= cnt_reg - 12'h001;
         end else begin
            cnt_reg <= cnt_reg + 12'h001;
         end
      end else begin
         countDown_reg <= 1'b0;
         cnt_reg <= atTop ? 12'h000 : cnt_reg + 12'h001;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < fcp_pkg::NUM_CH; ch++) begin : gChan
         wire [11:0] chCnt = cnt_reg - shift_reg[ch];
         // Inverted edge puts the on time at the end of the period
         wire [12:0] onEnd = {1'b0, chCnt} + {1'b0, onTime_reg[ch]};
         wire rawOn = invEdge ? (onEnd > {1'b0, maxCount})
            : (chCnt < onTime_reg[ch]);
         logic hsGated, lsGated;

         always_ff @(posedge clk) begin
            if (reset) begin
               onTime_reg[ch] <= fcp_pkg::WORD12_RESET;
               shift_reg[ch] <= fcp_pkg::WORD12_RESET;
               rawOn_reg[ch] <= 1'b0;
            end else begin
               if (hitReg(busReq.addr, 6'(fcp_pkg::REG_ON1 + ch))) begin
                  onTime_reg[ch] <= busReq.wdata[11:0];
               end
               if (hitReg(busReq.addr, 6'(fcp_pkg::REG_SHIFT1 + ch))) begin
                  shift_reg[ch] <= busReq.wdata[11:0];
               end
               rawOn_reg[ch] <= rawOn;
            end
         end

         fcp_dead_time uHigh (
            .clk(clk),
            .reset(reset),
            .raw(rawOn_reg[ch]),
            .delayTicks(dtHigh),
            .gated(hsGated)
         );
         fcp_dead_time uLow (
            .clk(clk),
            .reset(reset),
            .raw(!rawOn_reg[ch]),
            .delayTicks(dtLow),
            .gated(lsGated)
         );

         always_ff @(posedge clk) begin
            if (reset) begin
               highSide[ch] <= 1'b0;
               lowSide[ch] <= 1'b0;
            end else begin
               highSide[ch] <= hsGated ^ pol[fcp_pkg::POL_HIGH];
               lowSide[ch] <= lsGated ^ pol[fcp_pkg::POL_LOW];
            end
         end
      end
   endgenerate

   // Trigger pulse stretchers
   always_ff @(posedge clk) begin
      if (reset) begin
         zeroCnt_reg <= 8'h00;
         centerCnt_reg <= 8'h00;
         aCnt_reg <= 8'h00;
         bCnt_reg <= 8'h00;
      end else begin
         zeroCnt_reg <= pulseNext(zeroCnt_reg, zeroEvent,
            pulseWidth_reg);
         centerCnt_reg <= pulseNext(centerCnt_reg, centerEvent,
            pulseWidth_reg);
         aCnt_reg <= pulseNext(aCnt_reg, aEvent, pulseWidth_reg);
         bCnt_reg <= pulseNext(bCnt_reg, bEvent, pulseWidth_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pulseOut <= '0;
      end else begin
         pulseOut.zero <= (zeroCnt_reg != 8'h00)
            ^ pol[fcp_pkg::POL_ZERO];
         pulseOut.center <= (centerCnt_reg != 8'h00)
            ^ pol[fcp_pkg::POL_CENTER];
         pulseOut.a <= (aCnt_reg != 8'h00) ^ pol[fcp_pkg::POL_A];
         pulseOut.b <= (bCnt_reg != 8'h00) ^ pol[fcp_pkg::POL_B];
      end
   end

   // Event flags: a new event in the read cycle survives the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         flags_reg <= 24'h000000;
      end else begin
         flags_reg <= (flagRead ? 24'h000000 : flags_reg)
            | pwmEvents;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         common_event_interrupt_out <= 1'b0;
      end else begin
         common_event_interrupt_out <= |(flags_reg & irqEnable_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= 64'h0;
      end else begin
         rdata <= flagRead ? {40'h0, flags_reg} : 64'h0;
      end
   end

   chk_zero_single: assert property (
      @(posedge clk) disable iff (reset)
      zeroEvent && maxCount != 12'h000 && !cfgWrite |=> !zeroEvent)
      else $error("zero event longer than one cycle");
   chk_center_single: assert property (
      @(posedge clk) disable iff (reset)
      centerEvent && maxCount != 12'h000 && !cfgWrite |=> !centerEvent)
      else $error("center event longer than one cycle");
   chk_trig_a_start: assert property (
      @(posedge clk) disable iff (reset)
      aEvent && pulseWidth_reg != 8'h00 |=> aCnt_reg == $past(pulseWidth_reg))
      else $error("pulse A not started");
   chk_trig_b_start: assert property (
      @(posedge clk) disable iff (reset)
      bEvent && pulseWidth_reg != 8'h00 |=> bCnt_reg == $past(pulseWidth_reg))
      else $error("pulse B not started");
   chk_pulse_out_a: assert property (
      @(posedge clk) disable iff (reset)
      aCnt_reg != 8'h00 |=> pulseOut.a != $past(pol[fcp_pkg::POL_A]))
      else $error("A output not active");
   chk_pulse_out_zero: assert property (
      @(posedge clk) disable iff (reset)
      zeroCnt_reg != 8'h00 |=> pulseOut.zero != $past(pol[fcp_pkg::POL_ZERO]))
      else $error("zero output not active");
   chk_pulse_decay: assert property (
      @(posedge clk) disable iff (reset)
      aCnt_reg != 8'h00 && !aEvent |=> aCnt_reg == $past(aCnt_reg) - 8'h01)
      else $error("pulse A length counter skipped");
   chk_irq_or: assert property (
      @(posedge clk) disable iff (reset)
      |(flags_reg & irqEnable_reg) |=> common_event_interrupt_out)
      else $error("interrupt not raised");
   chk_irq_mask: assert property (
      @(posedge clk) disable iff (reset)
      (flags_reg & irqEnable_reg) == 24'h0 |=> !common_event_interrupt_out)
      else $error("masked interrupt raised");
   chk_flag_clear: assert property (
      @(posedge clk) disable iff (reset)
      flagRead && !(|pwmEvents) |=> flags_reg == 24'h0)
      else $error("flags not cleared by read");
   chk_flag_set: assert property (
      @(posedge clk) disable iff (reset)
      zeroEvent |=> flags_reg[fcp_pkg::EV_ZERO])
      else $error("zero flag lost");
   chk_rdata_flags: assert property (
      @(posedge clk) disable iff (reset)
      flagRead |=> rdata == {40'h0, $past(flags_reg)})
      else $error("flag read data wrong");
   chk_rdata_idle: assert property (
      @(posedge clk) disable iff (reset)
      !flagRead |=> rdata == 64'h0)
      else $error("read data without flag read");
   chk_cnt_wrap: assert property (
      @(posedge clk) disable iff (reset)
      !centerMode && atTop && $stable(cfg_reg) |=> cnt_reg == 12'h000)
      else $error("counter did not wrap");
   chk_cnt_bound: assert property (
      @(posedge clk) disable iff (reset)
      !cfgWrite && cnt_reg <= maxCount |=> cnt_reg <= maxCount)
      else $error("counter ran past max");
   chk_shift_on: assert property (
      @(posedge clk) disable iff (reset)
      !invEdge && (12'(cnt_reg - shift_reg[0]) < onTime_reg[0])
      |=> rawOn_reg[0])
      else $error("channel 0 not on");
   chk_off_zero: assert property (
      @(posedge clk) disable iff (reset)
      !invEdge && onTime_reg[0] == 12'h000 |=> !rawOn_reg[0])
      else $error("channel 0 on with zero on time");
   chk_no_overlap: assert property (
      @(posedge clk) disable iff (reset)
      $past(pol[1:0]) == 2'b00 |-> (highSide & lowSide) == 4'h0)
      else $error("high and low side on together");

   cov_a_pulse: cover property (@(posedge clk) aEvent ##1 aCnt_reg != 8'h00);
   cov_inv_edge: cover property (@(posedge clk) invEdge && rawOn_reg[0]);
   cov_irq: cover property (@(posedge clk) common_event_interrupt_out);
   cov_read_clear: cover property (@(posedge clk) flagRead && flags_reg != 0);
   cov_center_mode: cover property (@(posedge clk) centerMode && atTop);
endmodule

// [tb/fcp_gate_model.sv]
`timescale 1ns/100ps
// Power stage: counts cycles where both switches of one leg conduct
module fcp_gate_model (
   input wire logic clk,
   input wire logic [3:0] highSide,
   input wire logic [3:0] lowSide,
   output int overlapCount
);
   initial overlapCount = 0;
   always @(posedge clk) begin
      if ((|(highSide & lowSide)) === 1'b1) begin
         overlapCount <= overlapCount + 1;
      end
   end
endmodule

// [tb/test_fcp_pwm_top.sv]
`timescale 1ns/100ps
module test_fcp_pwm_top;
   logic clk = 1'b0;
   logic reset;
   fcp_pkg::fcp_req_t busReq;
   logic [63:0] rdata;
   logic [3:0] highSide;
   logic [3:0] lowSide;
   fcp_pkg::fcp_pulse_t pulseOut;
   logic common_event_interrupt_out;
   int overlapCount;
   int fail_count = 0;
   int cmp_count = 0;
   int hsCnt[4];
   int pCnt[4];
   int lsCnt[4];
   int irqCnt;
   logic [63:0] flagsVal;
   logic [11:0] onT[4];
   logic [11:0] pa;
   logic [11:0] pb;
   logic [7:0] w;
   int span;
   int k;

   always #2 clk = ~clk;

   fcp_pwm_top fcp_pwm_top_i (.clk(clk), .reset(reset), .busReq(busReq),
      .rdata(rdata), .highSide(highSide), .lowSide(lowSide),
      .pulseOut(pulseOut),
      .common_event_interrupt_out(common_event_interrupt_out));

   fcp_gate_model fcp_gate_model_i (.clk(clk), .highSide(highSide),
      .lowSide(lowSide), .overlapCount(overlapCount));

   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic wr(logic [5:0] a, logic [63:0] d);
      @(negedge clk);
      busReq.wr = 1'b1;
      busReq.addr = a;
      busReq.wdata = d;
      @(negedge clk);
      busReq.wr = 1'b0;
   endtask

   task automatic rd_flags();
      @(negedge clk);
      busReq.rd = 1'b1;
      busReq.addr = fcp_pkg::REG_FLAGS;
      @(negedge clk);
      busReq.rd = 1'b0;
      flagsVal = rdata;
   endtask

   // Waits for the period-start pulse to rise, so later events are far off
   task automatic wait_zero();
      int n;
      n = 0;
      while (pulseOut.zero !== 1'b0 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      while (pulseOut.zero !== 1'b1 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk("zeroSeen", 1, n < 9000);
   endtask

   task automatic measure(int sp);
      hsCnt = '{default: 0};
      pCnt = '{default: 0};
      lsCnt = '{default: 0};
      irqCnt = 0;
      repeat (sp) begin
         @(negedge clk);
         for (int c = 0; c < 4; c++) begin
            hsCnt[c] += (highSide[c] === 1'b1);
            lsCnt[c] += (lowSide[c] === 1'b1);
            pCnt[c] += (pulseOut[c] === 1'b1);
         end
         irqCnt += (common_event_interrupt_out === 1'b1);
      end
   endtask

   function automatic logic [63:0] cfgw(logic [1:0] al, logic [6:0] pol,
         logic [7:0] dl, logic [7:0] dh);
      cfgw = 64'h0000000000000fff;
      cfgw[fcp_pkg::CFG_ALIGN_LSB +: 2] = al;
      cfgw[fcp_pkg::CFG_POL_LSB +: 7] = pol;
      cfgw[fcp_pkg::CFG_DTLOW_LSB +: 8] = dl;
      cfgw[fcp_pkg::CFG_DTHIGH_LSB +: 8] = dh;
   endfunction

   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      finish_test();
   end

   initial begin
      reset = 1'b1;
      busReq = '0;
      void'($urandom(32'hd373));
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int m = 0; m < 4; m++) begin
         w = 8'($urandom_range(255, 1));
         pa = 12'($urandom_range(1800, 300));
         pb = 12'($urandom_range(1800, 300));
         wr(fcp_pkg::REG_CFG, cfgw(2'(m), 7'h00, 8'h00, 8'h00));
         for (int c = 0; c < 4; c++) begin
            onT[c] = (c == 0) ? 12'h000 : (c == 3) ? 12'hfff : 12'($urandom);
            wr(fcp_pkg::REG_ON1 + 6'(c), {52'h0, onT[c]});
            wr(fcp_pkg::REG_SHIFT1 + 6'(c), {32'h0, $urandom});
         end
         wr(6'h3f, {$urandom, $urandom});
         wr(fcp_pkg::REG_TRIGPOS, {36'h0, pb, 4'h0, pa});
         wr(fcp_pkg::REG_PULSEW, {56'h0, w});
         span = (m == 1) ? 8192 : 4096;
         k = (m == 1) ? 2 : 1;
         measure(span);
         measure(span);
         chk("pulseA", k * w, pCnt[1]);
         chk("pulseB", k * w, pCnt[0]);
         chk("pulseZero", w, pCnt[3]);
         chk("pulseCenter", w, pCnt[2]);
         for (int c = 0; c < 4; c++) begin
            chk("duty", k * onT[c], hsCnt[c]);
            chk("dutyLow", k * (4096 - onT[c]), lsCnt[c]);
         end
      end
      wr(fcp_pkg::REG_CFG, cfgw(2'h0, 7'h00, 8'($urandom_range(20, 1)),
         8'($urandom_range(20, 1))));
      for (int e = 12; e < 16; e++) begin
         wr(fcp_pkg::REG_IRQCFG, 64'h1 << e);
         wait_zero();
         rd_flags();
         repeat (3) @(negedge clk);
         chk("irqCleared", 0, common_event_interrupt_out);
         measure(4096);
         chk("irqSet", 1, common_event_interrupt_out);
         rd_flags();
         chk("flags", 4'hf, flagsVal[15:12]);
      end
      wr(fcp_pkg::REG_IRQCFG, {32'h0, $urandom & 32'hffff0fff});
      wait_zero();
      rd_flags();
      measure(4096);
      chk("irqMasked", 0, irqCnt);
      chk("overlap", 0, overlapCount);
      wr(fcp_pkg::REG_PULSEW, 64'h0);
      wr(fcp_pkg::REG_CFG, cfgw(2'h0, 7'h7b, 8'h00, 8'h00));
      measure(300);
      chk("pulsePol", 4'hf, pulseOut);
      chk("highPol", 1, highSide[0]);
      chk("lowPol", 0, lowSide[0]);
      finish_test();
   end
endmodule
